/* design/energy_acc_cfg.svh */
// Constants for the active power and energy accumulator: register offsets,
// field positions, reset values and timing counts.
// Assumes a single 20 MHz core clock and an AXI4-Lite register bus.
`ifndef ENERGY_ACC_CFG_SVH
`define ENERGY_ACC_CFG_SVH

`define OFS_POWER_GAIN     8'h00
`define OFS_ENERGY_TOTAL   8'h04
`define OFS_ENERGY_DIVIDER 8'h08
`define OFS_ENERGY_RDCLR   8'h0c
`define OFS_POWER_OFFSET   8'h10
`define OFS_MODE           8'h14
`define OFS_IRQ_STATUS     8'h18
`define OFS_IRQ_ENABLE     8'h1c
`define OFS_WAVEFORM       8'h20

`define MODE_POSITIVE_ONLY_ACCUMULATION_BIT      15
`define MODE_SRC_LSB       13
`define MODE_RATE_LSB      11
`define IRQ_SAMPLE_BIT     3

`define RST_POWER_GAIN     12'h000
`define RST_DIVIDER        8'h00
`define RST_OFFSET         16'h0000
`define RST_MODE           5'h00
`define RST_IRQ            5'h00

`define CLK_PERIOD_NS      50
`define STEP_CYCLES        4
`define WAVE_PERIOD_NS     35842
`define WAVE_CYCLES        (`WAVE_PERIOD_NS / `CLK_PERIOD_NS)
`define GAIN_ONE           14'sh1000
`define LPF_SHIFT          16

`endif

/* design/energy_acc_pkg.sv */
// Types shared by the energy accumulator design files.
// Assumes the constants header is included by the modules that need numbers.
package energy_acc_pkg;

  typedef struct packed {
    logic       positive_only_accumulation;
    logic [1:0] wave_src;
    logic [1:0] wave_rate;
  } mode_t;

  typedef struct packed {
    logic half_neg;
    logic sample_ready;
    logic half_pos;
    logic underflow;
    logic overflow;
  } irq_t;

endpackage

/* design/power_lowpass_filter.sv */
// First-order low-pass filter that extracts the dc part of power.
// Assumes one new input per step strobe on the same clock.
`timescale 1ns/1ps
module power_lowpass_filter #(
  parameter int W  = 32,
  parameter int SH = 16
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_rstn,
  input  wire logic                i_step,
  input  wire logic signed [W-1:0] i_x,
  output logic signed [W-1:0]      o_y
);
  logic signed [W+SH-1:0] state;

  // A leak of 2^-16 at a 5 MHz step rate puts the corner near 12.1 Hz.
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      state <= '0;
    else if (i_step)
      state <= state + (W+SH)'(i_x) - (state >>> SH);
  end

  assign o_y = state[W+SH-1:SH];
endmodule

/* design/energy_divider_unit.sv */
// Registered signed division of the scaled power by an unsigned divisor.
// Assumes the dividend is stable for several cycles between steps.
`timescale 1ns/1ps
module energy_divider_unit #(
  parameter int W = 34
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_rstn,
  input  wire logic signed [W-1:0] i_dividend,
  input  wire logic [7:0]          i_divisor,
  output logic signed [W-1:0]      o_quotient
);
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_quotient <= '0;
    else if (i_divisor == 8'h00)
      o_quotient <= i_dividend;
    else
      o_quotient <= W'(i_dividend / $signed({1'b0, i_divisor}));
  end

  property p_div_zero;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_divisor == 8'h00) |=> (o_quotient == $past(i_dividend));
  endproperty
  a_div_zero: assert property (p_div_zero)
    else $error("Divisor zero did not pass the dividend through.");
endmodule

/* design/active_power_energy_accumulator.sv */
// Active power datapath and 49-bit energy accumulator with AXI4-Lite access.
// Assumes current and voltage samples come from logic on the same clock.
`timescale 1ns/1ps
`include "energy_acc_cfg.svh"
module active_power_energy_accumulator
  import energy_acc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rstn,
  input  wire logic signed [23:0] i_current_sample,
  input  wire logic signed [15:0] i_voltage_sample,
  input  wire logic [ADDR_W-1:0]  i_awaddr,
  input  wire logic               i_awvalid,
  output logic                    o_awready,
  input  wire logic [31:0]        i_wdata,
  input  wire logic [3:0]         i_wstrb,
  input  wire logic               i_wvalid,
  output logic                    o_wready,
  output logic [1:0]              o_bresp,
  output logic                    o_bvalid,
  input  wire logic               i_bready,
  input  wire logic [ADDR_W-1:0]  i_araddr,
  input  wire logic               i_arvalid,
  output logic                    o_arready,
  output logic [31:0]             o_rdata,
  output logic [1:0]              o_rresp,
  output logic                    o_rvalid,
  input  wire logic               i_rready,
  output logic                    o_irq
);
  logic                rst_meta;
  logic                rstn;
  logic [1:0]          step_cnt;
  logic                step;
  logic signed [39:0]  product;
  logic signed [31:0]  lpf_out;
  logic signed [33:0]  with_offset;
  logic signed [47:0]  gain_prod;
  logic signed [33:0]  gained;
  logic signed [33:0]  quotient;
  logic signed [48:0]  acc;
  logic signed [48:0]  next_acc;
  logic                add_en;
  logic [11:0]         power_gain;
  logic [7:0]          energy_divider;
  logic [15:0]         power_offset;
  mode_t               mode;
  irq_t                irq_status;
  irq_t                irq_enable;
  irq_t                events;
  logic [23:0]         waveform;
  logic [12:0]         wave_cnt;
  logic                wave_tick;
  logic [ADDR_W-1:0]   aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                aw_held;
  logic                w_held;
  logic                do_write;
  logic                rc_clear;
  logic [23:0]         rc_snap;
  logic [31:0]         wmask;

  // Reset is released through two flops so every register leaves reset
  // on the same edge.
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta <= 1'b0;
      rstn     <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rstn     <= rst_meta;
    end
  end

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
      step_cnt <= '0;
    else
      step_cnt <= step_cnt + 2'd1;
  end
  assign step = (step_cnt == 2'(`STEP_CYCLES - 1));

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
      product <= '0;
    else if (step)
      product <= i_current_sample * i_voltage_sample;
  end

  // The product keeps eight fraction bits so the offset can act below one
  // waveform step.
  power_lowpass_filter #(
    .W  (32),
    .SH (`LPF_SHIFT)
  ) u_lpf (
    .i_core_clk (i_core_clk),
    .i_rstn     (rstn),
    .i_step     (step),
    .i_x        (product[39:8]),
    .o_y        (lpf_out)
  );

  always_comb
  begin
    with_offset = 34'(lpf_out) + 34'($signed(power_offset));
    gain_prod   = 48'(with_offset)
                * 48'(`GAIN_ONE + 14'($signed(power_gain)));
    gained      = gain_prod[45:12];
  end

  energy_divider_unit #(
    .W (34)
  ) u_div (
    .i_core_clk (i_core_clk),
    .i_rstn     (rstn),
    .i_dividend (gained),
    .i_divisor  (energy_divider),
    .o_quotient (quotient)
  );

  assign add_en = step && !(mode.positive_only_accumulation && quotient[33]);

  // A clearing read subtracts the captured top bits rather than zeroing
  // them, so a step landing in the same cycle is not lost.
  always_comb
  begin
    next_acc = acc + (add_en ? 49'(quotient) : 49'sd0);
    if (rc_clear)
      next_acc[48:25] = next_acc[48:25] - rc_snap;
  end

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
      acc <= '0;
    else
      acc <= next_acc;
  end

  always_comb
  begin
    events              = '0;
    events.overflow     = add_en && !quotient[33] && !acc[48]
                          && next_acc[48];
    events.underflow    = add_en && quotient[33] && acc[48]
                          && !next_acc[48];
    events.half_pos     = !next_acc[48] && next_acc[47]
                          && !(!acc[48] && acc[47]);
    events.half_neg     = next_acc[48] && !next_acc[47]
                          && !(acc[48] && !acc[47]);
    events.sample_ready = wave_tick && mode.wave_src == 2'b00
                          && irq_enable.sample_ready;
  end

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
      wave_cnt <= '0;
    else if (wave_tick)
      wave_cnt <= '0;
    else
      wave_cnt <= wave_cnt + 13'd1;
  end
  assign wave_tick = (wave_cnt ==
                      13'((`WAVE_CYCLES << mode.wave_rate) - 1));

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
      waveform <= '0;
    else if (events.sample_ready)
      waveform <= gained[31:8];
  end

  assign do_write = aw_held && w_held && !o_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                  {8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= '0;
      w_data    <= '0;
      w_strb    <= '0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'b00;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_addr   <= i_awaddr;
        aw_held   <= 1'b1;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_data   <= i_wdata;
        w_strb   <= i_wstrb;
        w_held   <= 1'b1;
        o_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        o_bvalid <= 1'b1;
        case (aw_addr)
          `OFS_POWER_GAIN, `OFS_ENERGY_DIVIDER, `OFS_POWER_OFFSET,
          `OFS_MODE, `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE,
          `OFS_ENERGY_TOTAL, `OFS_ENERGY_RDCLR, `OFS_WAVEFORM:
            o_bresp <= 2'b00;
          default:
            o_bresp <= 2'b10;
        endcase
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      power_gain     <= `RST_POWER_GAIN;
      energy_divider <= `RST_DIVIDER;
      power_offset   <= `RST_OFFSET;
      mode           <= `RST_MODE;
      irq_enable     <= `RST_IRQ;
    end
    else if (do_write)
    begin
      case (aw_addr)
        `OFS_POWER_GAIN:
          power_gain <= (power_gain & ~wmask[11:0])
                        | (w_data[11:0] & wmask[11:0]);
        `OFS_ENERGY_DIVIDER:
          energy_divider <= (energy_divider & ~wmask[7:0])
                            | (w_data[7:0] & wmask[7:0]);
        `OFS_POWER_OFFSET:
          power_offset <= (power_offset & ~wmask[15:0])
                          | (w_data[15:0] & wmask[15:0]);
        `OFS_MODE:
        begin
          if (w_strb[1])
          begin
            mode.positive_only_accumulation      <= w_data[`MODE_POSITIVE_ONLY_ACCUMULATION_BIT];
            mode.wave_src  <= w_data[`MODE_SRC_LSB+1:`MODE_SRC_LSB];
            mode.wave_rate <= w_data[`MODE_RATE_LSB+1:`MODE_RATE_LSB];
          end
        end
        `OFS_IRQ_ENABLE:
          if (w_strb[0])
            irq_enable <= w_data[4:0];
        default:
          power_gain <= power_gain;
      endcase
    end
  end

  // Hardware events win over a software clear in the same cycle.
  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
      irq_status <= `RST_IRQ;
    else if (do_write && aw_addr == `OFS_IRQ_STATUS && w_strb[0])
      irq_status <= (irq_status & ~irq_t'(w_data[4:0])) | events;
    else
      irq_status <= irq_status | events;
  end

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_status & irq_enable);
  end

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= 2'b00;
      rc_clear  <= 1'b0;
      rc_snap   <= '0;
    end
    else
    begin
      rc_clear <= 1'b0;
      if (i_arvalid && o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rresp   <= 2'b00;
        case (i_araddr)
          `OFS_POWER_GAIN:     o_rdata <= 32'(power_gain);
          `OFS_ENERGY_TOTAL:   o_rdata <= 32'(acc[48:25]);
          `OFS_ENERGY_DIVIDER: o_rdata <= 32'(energy_divider);
          `OFS_ENERGY_RDCLR:
          begin
            o_rdata  <= 32'(acc[48:25]);
            rc_snap  <= acc[48:25];
            rc_clear <= 1'b1;
          end
          `OFS_POWER_OFFSET:   o_rdata <= 32'(power_offset);
          `OFS_MODE:           o_rdata <= 32'({mode, 11'h000});
          `OFS_IRQ_STATUS:     o_rdata <= 32'(irq_status);
          `OFS_IRQ_ENABLE:     o_rdata <= 32'(irq_enable);
          `OFS_WAVEFORM:       o_rdata <= 32'(waveform);
          default:
          begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= 2'b10;
          end
        endcase
      end
      if (o_rvalid && i_rready)
      begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rstn);

  property p_step_period;
    step |=> !step [*3] ##1 step;
  endproperty
  a_step_period: assert property (p_step_period)
    else $error("Accumulation step is not every four cycles.");

  property p_signed_add;
    (add_en && !rc_clear) |=> (acc == $past(acc) + 49'($past(quotient)));
  endproperty
  a_signed_add: assert property (p_signed_add)
    else $error("Signed addition into the accumulator went wrong.");

  property p_positive_only_accumulation_drop;
    (step && mode.positive_only_accumulation && quotient[33] && !rc_clear) |=> $stable(acc);
  endproperty
  a_positive_only_accumulation_drop: assert property (p_positive_only_accumulation_drop)
    else $error("Negative sample reached accumulator in positive mode.");

  property p_rc_read;
    (i_arvalid && o_arready && i_araddr == `OFS_ENERGY_RDCLR && !step)
      |=> o_rvalid && o_rdata[23:0] == $past(acc[48:25])
          ##1 ($past(step) || acc[48:25] == 24'h000000);
  endproperty
  a_rc_read: assert property (p_rc_read)
    else $error("Clearing read returned or cleared the wrong value.");

  property p_ovf_flag;
    events.overflow |=> irq_status.overflow ##1 o_irq || !irq_enable.overflow;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("Overflow did not set its flag.");

  property p_irq_level;
    (|(irq_status & irq_enable)) |=> o_irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Enabled status bit did not raise the interrupt.");

  property p_wave_load;
    $changed(waveform) |-> $past(mode.wave_src) == 2'b00
                           && $past(irq_enable.sample_ready);
  endproperty
  a_wave_load: assert property (p_wave_load)
    else $error("Waveform loaded without source zero and enable.");

  property p_positive_only_accumulation_reset;
    $rose(rstn) |-> !mode.positive_only_accumulation;
  endproperty
  a_positive_only_accumulation_reset: assert property (@(posedge i_core_clk) p_positive_only_accumulation_reset)
    else $error("Positive-only mode is on after reset.");

  c_write: cover property (do_write);
  c_rc_read: cover property (rc_clear);
  c_overflow: cover property (events.overflow);
  c_sample: cover property (events.sample_ready);
endmodule

/* verification/adc_sample_source.sv */
// Model of the current and voltage sample paths feeding the accumulator.
// Assumes the core clock; samples change only just after rising edges.
`timescale 1ns/1ps
module adc_sample_source (
  input  wire logic               i_core_clk,
  input  wire logic               i_enable,
  input  wire logic signed [23:0] i_cur_level,
  input  wire logic signed [15:0] i_volt_level,
  output logic signed [23:0]      o_current_sample,
  output logic signed [15:0]      o_voltage_sample
);
  logic phase = 1'b0;

  // The outputs settle at the first edge, long before reset lets the
  // sampler act, so they need no initial value of their own.
  // Both channels flip sign together, so their product keeps one sign.
  always @(posedge i_core_clk)
  begin
    phase <= ~phase;
    o_current_sample <= !i_enable ? 24'sh000000 :
                        (phase ? -i_cur_level : i_cur_level);
    o_voltage_sample <= !i_enable ? 16'sh0000 :
                        (phase ? -i_volt_level : i_volt_level);
  end
endmodule

/* verification/active_power_energy_accumulator_tb.sv */
// Self-checking bench for the active power and energy accumulator.
// Assumes the design's constants header and the sample source model.
`timescale 1ns/1ps
`include "energy_acc_cfg.svh"
module active_power_energy_accumulator_tb;
  logic               clk = 1'b0;
  logic               rstn = 1'b0;
  logic [7:0]         awaddr = 8'h00;
  logic [7:0]         araddr = 8'h00;
  logic [31:0]        wdata = 32'h00000000;
  logic               awvalid = 1'b0;
  logic               wvalid = 1'b0;
  logic               bready = 1'b0;
  logic               arvalid = 1'b0;
  logic               rready = 1'b0;
  logic               src_en = 1'b0;
  logic signed [23:0] cur_lvl = 24'sh000000;
  logic signed [15:0] volt_lvl = 16'sh0000;
  logic signed [23:0] cur;
  logic signed [15:0] volt;
  logic               awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]         bresp, rresp, rs;
  logic [31:0]        rdata, r, d;
  int                 n_mismatch = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  int                 t_ar = 0;
  int                 t0 = 0;
  int                 tp = 0;
  int                 seed = 90023;
  logic [7:0]         ofs [5] = '{`OFS_POWER_GAIN, `OFS_ENERGY_DIVIDER,
                        `OFS_POWER_OFFSET, `OFS_MODE, `OFS_IRQ_ENABLE};
  logic [31:0]        msk [5] = '{32'h00000fff, 32'h000000ff,
                        32'h0000ffff, 32'h0000f800, 32'h0000001f};

  always #25 clk = ~clk;

  adc_sample_source src_u (
    .i_core_clk       (clk),
    .i_enable         (src_en),
    .i_cur_level      (cur_lvl),
    .i_volt_level     (volt_lvl),
    .o_current_sample (cur),
    .o_voltage_sample (volt)
  );

  active_power_energy_accumulator dut_u (
    .i_core_clk       (clk),
    .i_rstn           (rstn),
    .i_current_sample (cur),
    .i_voltage_sample (volt),
    .i_awaddr         (awaddr),
    .i_awvalid        (awvalid),
    .o_awready        (awready),
    .i_wdata          (wdata),
    .i_wstrb          (4'hf),
    .i_wvalid         (wvalid),
    .o_wready         (wready),
    .o_bresp          (bresp),
    .o_bvalid         (bvalid),
    .i_bready         (bready),
    .i_araddr         (araddr),
    .i_arvalid        (arvalid),
    .o_arready        (arready),
    .o_rdata          (rdata),
    .o_rresp          (rresp),
    .o_rvalid         (rvalid),
    .i_rready         (rready),
    .o_irq            (irq)
  );

  task give_verdict;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The whole run needs about 65000 cycles; a hang ends it here.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 99000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Energy window: a read lands within two steps of the cycle count, and
  // the bits left below the visible field after a clear add up to one.
  function automatic longint lim(input longint q, input int dt, input bit up);
    longint a, b;
    a = longint'(dt / 4 - 2) * q;
    b = longint'(dt / 4 + 2) * q;
    if (up)
      return ((a > b ? a : b) + 64'sd67108863) >>> 25;
    return ((a < b ? a : b) >>> 25) - 1;
  endfunction

  task automatic chk_e(input logic [31:0] got, input longint q, input int dt);
    longint g;
    g = longint'($signed(got[23:0]));
    cmp_count++;
    if ($isunknown(got) || got[31:24] != 8'h00 || g < lim(q, dt, 1'b0)
        || g > lim(q, dt, 1'b1))
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got,
               lim(q, dt, 1'b0));
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic ad, wd, ah, wh, bh;
    ad = 1'b0;
    wd = 1'b0;
    bh = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh)
    begin
      @(negedge clk);
      ah = (awready === 1'b1) & ~ad;
      wh = (wready === 1'b1) & ~wd;
      bh = (bvalid === 1'b1);
      rs = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      ad = ad | ah;
      wd = wd | wh;
    end
    bready <= 1'b0;
  endtask

  task automatic set(input logic [7:0] a, input logic [31:0] dat);
    wr(a, dat);
    chk({30'h0, rs}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ad, ah, rh;
    ad = 1'b0;
    rh = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh)
    begin
      @(negedge clk);
      ah = (arready === 1'b1) & ~ad;
      rh = (rvalid === 1'b1);
      r = rdata;
      rs = rresp;
      if (ah) t_ar = cyc;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      ad = ad | ah;
    end
    rready <= 1'b0;
  endtask

  task automatic wait_irq;
    repeat (2) @(negedge clk);
    while (irq !== 1'b1) @(negedge clk);
    t0 = cyc;
  endtask

  task automatic probe(input logic x);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, {31'h0, x});
  endtask

  task automatic wave(input logic [31:0] g, input logic [31:0] o,
                      input logic [31:0] x);
    set(`OFS_POWER_GAIN, g);
    set(`OFS_POWER_OFFSET, o);
    set(`OFS_IRQ_ENABLE, 32'h8);
    set(`OFS_IRQ_STATUS, 32'h1f);
    wait_irq;
    set(`OFS_IRQ_STATUS, 32'h8);
    wait_irq;
    rd(`OFS_WAVEFORM);
    chk(r, x);
  endtask

  task automatic erun(input logic [31:0] g, input logic [31:0] o,
                      input logic [31:0] dv, input logic [31:0] m,
                      input int n, input longint q);
    set(`OFS_POWER_GAIN, g);
    set(`OFS_POWER_OFFSET, o);
    set(`OFS_ENERGY_DIVIDER, dv);
    set(`OFS_MODE, m);
    rd(`OFS_ENERGY_RDCLR);
    t0 = t_ar;
    repeat (n) @(posedge clk);
    rd(`OFS_ENERGY_TOTAL);
    chk_e(r, q, t_ar - t0);
    rd(`OFS_ENERGY_RDCLR);
    chk_e(r, q, t_ar - t0);
    t0 = t_ar;
    rd(`OFS_ENERGY_TOTAL);
    chk_e(r, q, t_ar - t0);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      rd(8'(i * 4));
      chk(r, 32'h0);
    end
    for (int i = 0; i < 5; i++)
    begin
      d = $random(seed);
      set(ofs[i], d);
      rd(ofs[i]);
      chk(r, d & msk[i]);
      set(ofs[i], 32'h0);
    end
    wr(8'h40, 32'h1);
    chk({30'h0, rs}, 32'h2);
    rd(8'h40);
    chk({r[29:0], rs}, 32'h2);
    // The random offset above ran into the accumulator for a few steps.
    rd(`OFS_ENERGY_RDCLR);
    set(`OFS_ENERGY_TOTAL, 32'h00123456);
    rd(`OFS_ENERGY_TOTAL);
    chk(r, 32'h0);
    wave(32'h0, 32'h0100, 32'h1);
    wave(32'h7ff, 32'h1000, 32'h17);
    wave(32'h800, 32'h1000, 32'h8);
    set(`OFS_IRQ_ENABLE, 32'h0);
    probe(1'b0);
    set(`OFS_IRQ_ENABLE, 32'h8);
    probe(1'b1);
    set(`OFS_IRQ_STATUS, 32'h8);
    probe(1'b0);
    for (int k = 0; k < 4; k++)
    begin
      set(`OFS_MODE, 32'(k) << 11);
      set(`OFS_IRQ_STATUS, 32'h8);
      wait_irq;
      tp = t0;
      set(`OFS_IRQ_STATUS, 32'h8);
      wait_irq;
      chk(32'(t0 - tp), 32'(`WAVE_CYCLES << k));
    end
    erun(32'h7ff, 32'h7fff, 32'h0, 32'h0, 8000, 49142);
    erun(32'h7ff, 32'h7fff, 32'h2, 32'h0, 8000, 24571);
    erun(32'h0, 32'h8000, 32'h0, 32'h8000, 10000, 0);
    erun(32'h0, 32'h8000, 32'h0, 32'h0, 10000, -32768);
    @(posedge clk);
    src_en <= 1'b1;
    cur_lvl <= 24'sh400000;
    volt_lvl <= 16'sh4000;
    set(`OFS_POWER_OFFSET, 32'h0);
    rd(`OFS_ENERGY_RDCLR);
    repeat (3000) @(posedge clk);
    rd(`OFS_ENERGY_TOTAL);
    chk({31'h0, (r[31:23] === 9'h0 && r !== 32'h0)}, 32'h1);
    give_verdict;
  end
endmodule
